// *** core/dcw_decoder.sv ***
// command word decoder with holding register map and drive action outputs
`timescale 1ns/1ps

// What this block does
// - command bits 01/00 pick preset reference one to four.
// - bit 02 low means dc brake and stop; high means normal ramping.
// - bit 03 low shuts the output stage off so the motor coasts.
// - bit 04 low ramps down with the quick-stop ramp.
// - bit 05 low freezes output frequency; only speed pins change it.
// - while frozen only coast, dc brake or their pins stop the drive.
// - bit 06 low ramps to stop; high permits start.
// - trip cleared only on a rising edge of bit 07.
// - bit 08 high runs at jog speed.
// - bit 09 selects ramp set one or two.
// - bit 10 low makes the whole command word ignored.
// - bit 11 drives relay 1 only when its function is 36.
// - bit 12 drives relay 2 only when its function is 37.
// - bit 13 picks set-up two, effective only under multi set-up 9.
// - bit 15 reverses when reversing source is bus, or, and.
// - preset, coast, start, set-up bits gate with pins per selection.
// - command, reference at 50000/50010; state, value at 50200/50210.
// - aliases 02810/02811 and 02910/02911 behave like the primaries.
// - reference and main value are signed, 16384 equals 100 percent.
module dcw_decoder #(
    parameter int DATA_W = dcw_pkg::WORD_W
) (
    input  wire logic                 ref_clk,       // control clock
    input  wire logic                 resetn,        // sync reset, low
    input  wire logic                 clkEn,         // clock enable
    input  wire dcw_pkg::dcw_reg_req_s regIn,        // register access
    output logic [DATA_W-1:0]         regRdata,      // read data
    output logic                      regAck,        // access done
    output logic                      regErr,        // access refused
    input  wire logic [DATA_W-1:0]    driveStateWord, // drive state
    input  wire logic [DATA_W-1:0]    outputFreqValue, // output freq
    input  wire logic [1:0]           pinPresetSel,  // preset pins
    input  wire logic                 pinCoastReq,   // coast pin
    input  wire logic                 pinStart,      // start pin
    input  wire logic                 pinSetup2,     // set-up pin
    input  wire logic                 pinReverse,    // reverse pin
    input  wire logic                 pinDcBrake,    // dc brake pin
    input  wire logic                 pinCoastStop,  // coast stop pin
    input  wire logic                 pinResetCoast, // reset+coast pin
    input  wire dcw_pkg::dcw_gate_e   gatePreset,    // preset gating
    input  wire dcw_pkg::dcw_gate_e   gateCoast,     // coast gating
    input  wire dcw_pkg::dcw_gate_e   gateStart,     // start gating
    input  wire dcw_pkg::dcw_gate_e   gateSetup,     // set-up gating
    input  wire dcw_pkg::dcw_gate_e   gateReverse,   // reverse gating
    input  wire logic [7:0]           relay1Func,    // relay 1 function
    input  wire logic [7:0]           relay2Func,    // relay 2 function
    input  wire logic [3:0]           activeSetup,   // active set-up
    output dcw_pkg::dcw_cmd_s         driveCmd,      // decoded actions
    output logic [DATA_W-1:0]         busReference   // speed reference
);

    // the register map and field layout are fixed at sixteen bits
    if (DATA_W != dcw_pkg::WORD_W) begin
        $error("dcw_decoder: DATA_W must be 16");
    end

    // all state of this block
    typedef struct packed {
        logic [DATA_W-1:0] cmdWord;   // last accepted command word
        logic [DATA_W-1:0] busRef;    // bus speed reference
        logic              prevReset; // reset bit of previous word
        logic [DATA_W-1:0] rdData;    // read data register
        logic              ack;       // access acknowledge
        logic              err;       // access refused
        dcw_pkg::dcw_cmd_s cmd;       // registered drive actions
    } dcw_state_s;

    dcw_state_s state_q;
    dcw_state_s state_d;

    // map a register number, primary or alias, to its register
    function automatic dcw_pkg::dcw_kind_e regKind(
        input logic [15:0] addr
    );
        dcw_pkg::dcw_kind_e k;
        k = dcw_pkg::RK_NONE;
        case (addr)
            dcw_pkg::REG_CMD_WORD,   dcw_pkg::REG_CMD_ALIAS:
                k = dcw_pkg::RK_CMD;
            dcw_pkg::REG_BUS_REF,    dcw_pkg::REG_REF_ALIAS:
                k = dcw_pkg::RK_REF;
            dcw_pkg::REG_STATE_WORD, dcw_pkg::REG_STATE_ALIAS:
                k = dcw_pkg::RK_STATE;
            dcw_pkg::REG_MAIN_VALUE, dcw_pkg::REG_MAIN_ALIAS:
                k = dcw_pkg::RK_MAIN;
            default:
                k = dcw_pkg::RK_NONE;
        endcase
        return k;
    endfunction

    // synchronised pin levels; pins come from outside the clock domain
    logic [1:0] sPresetSel;
    logic       sCoastReq;
    logic       sStart;
    logic       sSetup2;
    logic       sReverse;
    logic       sDcBrake;
    logic       sCoastStop;
    logic       sResetCoast;

    dcw_sync #(
        .W (9)
    ) u_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .clkEn   (clkEn),
        .pinIn   ({pinPresetSel, pinCoastReq, pinStart, pinSetup2,
                   pinReverse, pinDcBrake, pinCoastStop, pinResetCoast}),
        .syncOut ({sPresetSel, sCoastReq, sStart, sSetup2,
                   sReverse, sDcBrake, sCoastStop, sResetCoast})
    );

    // bus side of each gated function, taken from the held word
    logic [DATA_W-1:0] cw;
    logic [1:0]        busPreset;
    logic              busCoast;
    logic              busStart;
    logic              busSetup2;
    logic              busReverse;

    assign cw         = state_q.cmdWord;
    assign busPreset  = {cw[dcw_pkg::BIT_PRESET_MSB],
                         cw[dcw_pkg::BIT_PRESET_LSB]};
    assign busCoast   = ~cw[dcw_pkg::BIT_COAST_N];
    assign busStart   = cw[dcw_pkg::BIT_START];
    assign busSetup2  = cw[dcw_pkg::BIT_SETUP];
    assign busReverse = cw[dcw_pkg::BIT_REVERSE];

    // combined bus and pin values
    logic [1:0] gPreset;
    logic       gCoast;
    logic       gStart;
    logic       gSetup2;
    logic       gReverse;

    // each function has its own gating selection
    dcw_gate #(.W(2)) u_gate_preset (
        .sel    (gatePreset),
        .busVal (busPreset),
        .pinVal (sPresetSel),
        .outVal (gPreset)
    );

    dcw_gate #(.W(1)) u_gate_coast (
        .sel    (gateCoast),
        .busVal (busCoast),
        .pinVal (sCoastReq),
        .outVal (gCoast)
    );

    dcw_gate #(.W(1)) u_gate_start (
        .sel    (gateStart),
        .busVal (busStart),
        .pinVal (sStart),
        .outVal (gStart)
    );

    dcw_gate #(.W(1)) u_gate_setup (
        .sel    (gateSetup),
        .busVal (busSetup2),
        .pinVal (sSetup2),
        .outVal (gSetup2)
    );

    // pin-only selection leaves the bus bit without effect
    dcw_gate #(.W(1)) u_gate_reverse (
        .sel    (gateReverse),
        .busVal (busReverse),
        .pinVal (sReverse),
        .outVal (gReverse)
    );

    // next state: register access, word acceptance and action decode
    always_comb begin
        dcw_pkg::dcw_kind_e kind;
        logic               newWord;
        logic               frozen;
        logic               hardStop;
        logic [DATA_W-1:0]  wordIn;

        state_d  = state_q;
        kind     = regKind(regIn.addr);
        newWord  = 1'b0;
        wordIn   = regIn.wdata;
        frozen   = 1'b0;
        hardStop = 1'b0;

        // acknowledge and error are single-cycle pulses
        state_d.ack = 1'b0;
        state_d.err = 1'b0;

        if (regIn.req) begin
            state_d.ack = 1'b1;
            if (regIn.write) begin
                case (kind)
                    dcw_pkg::RK_CMD: begin
                        // an invalid word leaves the held word untouched
                        if (wordIn[dcw_pkg::BIT_VALID]) begin
                            wordIn[dcw_pkg::BIT_UNUSED] = 1'b0;
                            state_d.cmdWord = wordIn;
                            newWord = 1'b1;
                        end
                    end
                    dcw_pkg::RK_REF: begin
                        state_d.busRef = regIn.wdata;
                    end
                    default: begin
                        // read-only or unmapped register
                        state_d.err = 1'b1;
                    end
                endcase
            end else begin
                case (kind)
                    dcw_pkg::RK_CMD:   state_d.rdData = state_q.cmdWord;
                    dcw_pkg::RK_REF:   state_d.rdData = state_q.busRef;
                    dcw_pkg::RK_STATE: state_d.rdData = driveStateWord;
                    dcw_pkg::RK_MAIN:  state_d.rdData = outputFreqValue;
                    default: begin
                        state_d.rdData = '0;
                        state_d.err    = 1'b1;
                    end
                endcase
            end
        end

        // trip clear fires once per accepted word whose reset bit rose
        state_d.cmd.tripReset = 1'b0;
        if (newWord) begin
            state_d.prevReset = wordIn[dcw_pkg::BIT_RESET];
            if (wordIn[dcw_pkg::BIT_RESET]
                && !state_q.prevReset) begin
                state_d.cmd.tripReset = 1'b1;
            end
        end

        // actions follow the held word, so they persist between writes
        frozen = ~cw[dcw_pkg::BIT_HOLD_N];
        state_d.cmd.presetSel  = gPreset;
        state_d.cmd.dcBrake    = ~cw[dcw_pkg::BIT_DC_BRAKE_N]
                                 | sDcBrake;
        state_d.cmd.coast      = gCoast | sCoastStop
                                 | sResetCoast;
        state_d.cmd.freezeFreq = frozen;
        hardStop = state_d.cmd.dcBrake | state_d.cmd.coast;

        // a frozen drive ignores ramped stops; only hard stops act
        if (frozen) begin
            state_d.cmd.quickStop = 1'b0;
            state_d.cmd.rampStop  = 1'b0;
        end else begin
            state_d.cmd.quickStop = ~cw[dcw_pkg::BIT_QSTOP_N]
                                    & ~hardStop;
            state_d.cmd.rampStop  = ~gStart & ~hardStop;
        end

        state_d.cmd.jog      = cw[dcw_pkg::BIT_JOG];
        state_d.cmd.rampSet2 = cw[dcw_pkg::BIT_RAMP2];

        // relays: unowned relay keeps whatever its other function says
        state_d.cmd.relay1Own = (relay1Func == dcw_pkg::RELAY1_BY_CMD);
        state_d.cmd.relay1On  = state_d.cmd.relay1Own
                                & cw[dcw_pkg::BIT_RELAY1];
        state_d.cmd.relay2Own = (relay2Func == dcw_pkg::RELAY2_BY_CMD);
        state_d.cmd.relay2On  = state_d.cmd.relay2Own
                                & cw[dcw_pkg::BIT_RELAY2];

        // set-up choice only counts under multi set-up
        state_d.cmd.setupOwn  = (activeSetup == dcw_pkg::SETUP_MULTI);
        state_d.cmd.setupSel2 = state_d.cmd.setupOwn & gSetup2;

        state_d.cmd.reverse   = gReverse;
    end

    // reset clears every action and loads a zero command word
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_q.cmdWord   <= dcw_pkg::CMD_RESET;
            state_q.busRef    <= dcw_pkg::REF_RESET;
            state_q.prevReset <= 1'b0;
            state_q.rdData    <= '0;
            state_q.ack       <= 1'b0;
            state_q.err       <= 1'b0;
            state_q.cmd       <= '0;
        end else if (clkEn) begin
            state_q <= state_d;
        end
    end

    // every output straight from the state register
    assign regRdata     = state_q.rdData;
    assign regAck       = state_q.ack;
    assign regErr       = state_q.err;
    assign driveCmd     = state_q.cmd;
    assign busReference = state_q.busRef;

endmodule

// *** core/dcw_pkg.sv ***
// shared constants and carrier types for the drive command word decoder
package dcw_pkg;

    // data width of every holding register
    localparam int          WORD_W          = 16;

    // holding register numbers, primary map
    localparam logic [15:0] REG_CMD_WORD    = 16'hc350;
    localparam logic [15:0] REG_BUS_REF     = 16'hc35a;
    localparam logic [15:0] REG_STATE_WORD  = 16'hc418;
    localparam logic [15:0] REG_MAIN_VALUE  = 16'hc422;
    // holding register numbers, lower alias map
    localparam logic [15:0] REG_CMD_ALIAS   = 16'h0afa;
    localparam logic [15:0] REG_REF_ALIAS   = 16'h0afb;
    localparam logic [15:0] REG_STATE_ALIAS = 16'h0b5e;
    localparam logic [15:0] REG_MAIN_ALIAS  = 16'h0b5f;

    // reset values
    localparam logic [15:0] CMD_RESET       = 16'h0000;
    localparam logic [15:0] REF_RESET       = 16'h0000;

    // command word bit positions
    localparam int          BIT_PRESET_LSB  = 0;
    localparam int          BIT_PRESET_MSB  = 1;
    localparam int          BIT_DC_BRAKE_N  = 2;
    localparam int          BIT_COAST_N     = 3;
    localparam int          BIT_QSTOP_N     = 4;
    localparam int          BIT_HOLD_N      = 5;
    localparam int          BIT_START       = 6;
    localparam int          BIT_RESET       = 7;
    localparam int          BIT_JOG         = 8;
    localparam int          BIT_RAMP2       = 9;
    localparam int          BIT_VALID       = 10;
    localparam int          BIT_RELAY1      = 11;
    localparam int          BIT_RELAY2      = 12;
    localparam int          BIT_SETUP       = 13;
    localparam int          BIT_UNUSED      = 14;
    localparam int          BIT_REVERSE     = 15;

    // relay function settings that hand a relay to the command word
    localparam logic [7:0]  RELAY1_BY_CMD   = 8'h24;
    localparam logic [7:0]  RELAY2_BY_CMD   = 8'h25;
    // active set-up value meaning multi set-up
    localparam logic [3:0]  SETUP_MULTI     = 4'h9;
    // full scale of reference and main value (100 percent)
    localparam logic [15:0] REF_FULL_SCALE  = 16'h4000;

    // gating selection between pin and bus
    typedef enum logic [1:0] {
        GATE_PIN = 2'b00,
        GATE_BUS = 2'b01,
        GATE_AND = 2'b10,
        GATE_OR  = 2'b11
    } dcw_gate_e;

    // register access kinds after decode
    typedef enum logic [2:0] {
        RK_NONE  = 3'b000,
        RK_CMD   = 3'b001,
        RK_REF   = 3'b010,
        RK_STATE = 3'b011,
        RK_MAIN  = 3'b100
    } dcw_kind_e;

    // decoded drive actions
    typedef struct packed {
        logic [1:0] presetSel;   // preset reference index
        logic       dcBrake;     // dc braking and stop
        logic       coast;       // output stage off
        logic       quickStop;   // quick-stop ramp
        logic       freezeFreq;  // hold output frequency
        logic       rampStop;    // ramp to stop
        logic       tripReset;   // one-cycle trip clear
        logic       jog;         // jog speed
        logic       rampSet2;    // second ramp set
        logic       relay1Own;   // relay 1 follows command word
        logic       relay1On;    // relay 1 energised
        logic       relay2Own;   // relay 2 follows command word
        logic       relay2On;    // relay 2 energised
        logic       setupOwn;    // set-up selection effective
        logic       setupSel2;   // set-up two selected
        logic       reverse;     // reverse direction
    } dcw_cmd_s;

    // holding register access request
    typedef struct packed {
        logic        req;        // access strobe
        logic        write;      // 1 write, 0 read
        logic [15:0] addr;       // register number
        logic [15:0] wdata;      // write data
    } dcw_reg_req_s;

endpackage

// *** core/dcw_sync.sv ***
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module dcw_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,  // control clock
    input  wire logic         resetn,   // sync reset, active low
    input  wire logic         clkEn,    // clock enable
    input  wire logic [W-1:0] pinIn,    // raw pin levels
    output logic      [W-1:0] syncOut   // synchronised levels
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            meta_q  <= '0;
            syncOut <= '0;
        end else if (clkEn) begin
            meta_q  <= pinIn;
            syncOut <= meta_q;
        end
    end
endmodule

// *** core/dcw_gate.sv ***
// combines a bus command bit with its pin counterpart
`timescale 1ns/1ps
module dcw_gate #(
    parameter int W = 1
) (
    input  wire dcw_pkg::dcw_gate_e sel,     // gating selection
    input  wire logic [W-1:0]       busVal,  // value from command word
    input  wire logic [W-1:0]       pinVal,  // value from digital input
    output logic      [W-1:0]       outVal   // combined value
);
    // pure combinational; the caller registers the result
    always_comb begin
        case (sel)
            dcw_pkg::GATE_PIN: outVal = pinVal;
            dcw_pkg::GATE_BUS: outVal = busVal;
            dcw_pkg::GATE_AND: outVal = busVal & pinVal;
            dcw_pkg::GATE_OR:  outVal = busVal | pinVal;
            default:           outVal = pinVal;
        endcase
    end
endmodule

// *** sim/dcw_decoder_asserts.sv ***
// concurrent checks on the command word decoder ports
`timescale 1ns/1ps
module dcw_decoder_asserts #(
    parameter int DATA_W = 16
) (
    input  wire logic                  ref_clk, // clock
    input  wire logic                  resetn, // reset, low
    input  wire logic                  clkEn, // enable
    input  wire dcw_pkg::dcw_reg_req_s regIn, // access
    input  wire logic [DATA_W-1:0]     regRdata, // read data
    input  wire logic                  regAck, // done
    input  wire logic                  regErr, // refused
    input  wire logic [DATA_W-1:0]     driveStateWord, // state
    input  wire logic [DATA_W-1:0]     outputFreqValue, // freq
    input  wire dcw_pkg::dcw_gate_e    gatePreset, // gating
    input  wire logic [7:0]            relay1Func, // relay 1 fn
    input  wire dcw_pkg::dcw_cmd_s     driveCmd // actions
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    logic        take, isCmd, isRef, isSta, isMain, cmdWr, tripRise;
    logic [15:0] shadow_q;
    // decode of the access taken this cycle, primaries and aliases
    assign take  = regIn.req && clkEn;
    assign isCmd = regIn.addr inside {16'hc350, 16'h0afa};
    assign isRef = regIn.addr inside {16'hc35a, 16'h0afb};
    assign isSta = regIn.addr inside {16'hc418, 16'h0b5e};
    assign isMain = regIn.addr inside {16'hc422, 16'h0b5f};
    assign cmdWr = take && regIn.write && isCmd && regIn.wdata[10];
    assign tripRise = cmdWr && regIn.wdata[7] && !shadow_q[7];
    // shadow of the accepted word, so decode checks need no model
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            shadow_q <= 16'h0;
        end else if (cmdWr) begin
            shadow_q <= regIn.wdata & 16'hbfff;
        end
    end
    sequence readOf(logic hit);
        take && !regIn.write && hit;
    endsequence
    ack_follows_req_a: assert property (take |=> regAck)
        else $error("no acknowledge");
    ack_has_cause_a: assert property (regAck |-> $past(take))
        else $error("stray acknowledge");
    state_read_a: assert property (readOf(isSta) |=>
        regRdata == $past(driveStateWord) && !regErr)
        else $error("state read wrong");
    main_read_a: assert property (readOf(isMain) |=>
        regRdata == $past(outputFreqValue) && !regErr)
        else $error("main read wrong");
    ro_write_err_a: assert property (take && regIn.write &&
        (isSta || isMain) |=> regErr)
        else $error("output write taken");
    unmapped_err_a: assert property (readOf(!(isCmd || isRef ||
        isSta || isMain)) |=> regErr && regRdata == '0)
        else $error("unmapped read taken");
    trip_pulse_a: assert property (tripRise |=>
        driveCmd.tripReset ##1 !driveCmd.tripReset)
        else $error("trip not a pulse");
    trip_cause_a: assert property (driveCmd.tripReset |->
        $past(tripRise))
        else $error("stray trip");
    preset_bus_a: assert property ($past(gatePreset) ==
        dcw_pkg::GATE_BUS |-> driveCmd.presetSel == $past(shadow_q[1:0]))
        else $error("preset selection wrong");
    jog_ramp_map_a: assert property (driveCmd.jog ==
        $past(shadow_q[8]) && driveCmd.rampSet2 == $past(shadow_q[9]))
        else $error("jog or ramp set wrong");
    relay1_map_a: assert property (driveCmd.relay1On ==
        ($past(relay1Func) == 8'h24 && $past(shadow_q[11])))
        else $error("relay 1 wrong");
    stop_blocked_a: assert property (driveCmd.freezeFreq ||
        driveCmd.coast || driveCmd.dcBrake |->
        !(driveCmd.quickStop || driveCmd.rampStop))
        else $error("ramp stop not blocked");
    // the first edge after reset still shows the cleared actions
    dc_brake_a: assert property ($past(resetn) &&
        !$past(shadow_q[2]) |-> driveCmd.dcBrake)
        else $error("dc brake missing");
endmodule
bind dcw_decoder dcw_decoder_asserts #(.DATA_W(DATA_W)) u_asserts (.*);

// *** sim/dcw_master.sv ***
// fieldbus master model issuing single holding register accesses
`timescale 1ns/1ps
module dcw_master (
    input  wire logic             ref_clk,  // control clock
    input  wire logic [15:0]      regRdata, // read data
    input  wire logic             regAck,   // access done
    input  wire logic             regErr,   // access refused
    output dcw_pkg::dcw_reg_req_s regIn     // access request
);
    initial regIn = '0;
    // req stands one cycle only: each cycle with req high is an access
    task automatic acc(input logic wr, input logic [15:0] a, d,
                       output logic [15:0] rd, output logic er, ok);
        ok = 1'b0;
        rd = 16'h0;
        er = 1'b0;
        @(posedge ref_clk);
        regIn <= '{req: 1'b1, write: wr, addr: a, wdata: d};
        @(posedge ref_clk);
        // idle lines show the inverse, never a stale request
        regIn <= '{req: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge ref_clk);
            if (regAck === 1'b1) begin
                ok = 1'b1;
                rd = regRdata;
                er = regErr;
            end
        end
    endtask
endmodule

// *** sim/tb.sv ***
// randomised self-checking bench for the command word decoder
`timescale 1ns/1ps
module tb;
    logic                  ref_clk, resetn, clkEn, regAck, regErr;
    dcw_pkg::dcw_reg_req_s regIn;
    logic [15:0]           regRdata, driveStateWord, outputFreqValue;
    logic [1:0]            pinPresetSel;
    logic                  pinCoastReq, pinStart, pinSetup2, pinReverse;
    logic                  pinDcBrake, pinCoastStop, pinResetCoast;
    dcw_pkg::dcw_gate_e    gatePreset, gateCoast, gateStart;
    dcw_pkg::dcw_gate_e    gateSetup, gateReverse;
    logic [7:0]            relay1Func, relay2Func;
    logic [3:0]            activeSetup;
    dcw_pkg::dcw_cmd_s     driveCmd;
    logic [15:0]           busReference, cw, rd, w, v, a;
    logic [31:0]           seed;
    logic                  er, ok;
    int                    err_count, n_compared;
    dcw_decoder dut (.*);
    dcw_master mst (.*);
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction
    // expected actions with bus gating, owned relays, multi set-up
    function automatic logic [15:0] expAct(input logic [15:0] c);
        logic blk;
        blk = !c[5] || !c[2] || !c[3];
        return {c[1:0], !c[2], !c[3], !c[4] && !blk, !c[5],
                !c[6] && !blk, c[8], c[9], c[11], c[12], c[13], c[15], 3'h0};
    endfunction
    // same order as expAct, tripReset and ownership left out
    function automatic logic [15:0] seenAct();
        return {driveCmd[16:10], driveCmd[8:7], driveCmd[5], driveCmd[3],
                driveCmd[1:0], 3'h0};
    endfunction
    task automatic check(input string what, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // one access, answered and refused only where expected
    task automatic access(input logic wr, input logic [15:0] ad, d,
                          input logic expErr);
        mst.acc(wr, ad, d, rd, er, ok);
        check("ack", {15'h0, ok}, 16'h1);
        check("err", {15'h0, er}, {15'h0, expErr}); // refusal
    endtask
    // command write; the pulse is read at the answering edge
    task automatic wrCmd(input logic [15:0] ad, d);
        logic tr;
        tr = d[10] && d[7] && !cw[7];
        access(1'b1, ad, d, 1'b0);
        check("trip", {15'h0, driveCmd.tripReset}, {15'h0, tr});
        if (d[10]) begin
            cw = d & 16'hbfff;
        end
    endtask
    initial begin
        seed = 32'haa51;
        {cw, err_count, n_compared, resetn} = '0;
        {pinPresetSel, pinCoastReq, pinStart, pinSetup2, pinReverse} = '0;
        {pinDcBrake, pinCoastStop, pinResetCoast} = '0;
        {driveStateWord, outputFreqValue} = '0;
        clkEn = 1'b1;
        gatePreset = dcw_pkg::GATE_BUS;
        gateCoast = gatePreset;
        gateStart = gatePreset;
        gateSetup = gatePreset;
        gateReverse = gatePreset;
        relay1Func = dcw_pkg::RELAY1_BY_CMD;
        relay2Func = dcw_pkg::RELAY2_BY_CMD;
        activeSetup = dcw_pkg::SETUP_MULTI;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        // reset values of the writable words, primaries and aliases
        for (int i = 0; i < 4; i++) begin
            a = i[1] ? (i[0] ? 16'h0afb : 16'h0afa)
                     : (i[0] ? 16'hc35a : 16'hc350);
            access(1'b0, a, 16'h0, 1'b0);
            check("reset", rd, 16'h0); // cleared at reset
            driveStateWord <= rnd();
            outputFreqValue <= rnd();
            a = i[1] ? (i[0] ? 16'h0b5f : 16'h0b5e)
                     : (i[0] ? 16'hc422 : 16'hc418);
            access(1'b0, a, 16'h0, 1'b0);
            check("out", rd, i[0] ? outputFreqValue : driveStateWord);
            access(1'b1, a, rnd(), 1'b1); // output words read only
        end
        access(1'b0, 16'hc351, 16'h0, 1'b1); // next to a mapped word
        check("unmapped", rd, 16'h0); // refused read gives zero
        access(1'b0, 16'h0afc, 16'h0, 1'b1); // past the alias block
        // random words with corners: valid gate, trip edges, bit 14
        for (int i = 0; i < 40; i++) begin
            w = (i == 0) ? 16'h0400 : (i < 3) ? 16'h0480 : rnd();
            w = (i == 3) ? 16'hffff : (i == 4) ? 16'h0000 : w;
            a = w[14] ? 16'hc350 : 16'h0afa;
            wrCmd(a, w);
            repeat (2) @(posedge ref_clk);
            check("act", seenAct(), expAct(cw)); // decode
            access(1'b0, a ^ 16'hc9aa, 16'h0, 1'b0);
            check("cmd", rd, cw); // alias readback
            v = (i == 5) ? 16'hc000 : rnd(); // minus full scale
            access(1'b1, v[3] ? 16'hc35a : 16'h0afb, v, 1'b0);
            check("ref", busReference, v); // reference held
        end
        // pin and bus gating for the preset selection
        for (int g = 0; g < 4; g++) begin
            gatePreset <= dcw_pkg::dcw_gate_e'(g[1:0]);
            w = rnd();
            pinPresetSel <= w[1:0];
            repeat (6) @(posedge ref_clk);
            v = {14'h0, g == 0 ? w[1:0] : g == 1 ? cw[1:0]
                      : g == 2 ? w[1:0] & cw[1:0] : w[1:0] | cw[1:0]};
            check("gate", {14'h0, driveCmd.presetSel}, v);
        end
        // relay 1, set-up and reverse not handed to the bus; pin brake
        wrCmd(16'hc350, 16'hbc7e);
        relay1Func <= 8'h00;
        activeSetup <= 4'h0;
        gateReverse <= dcw_pkg::GATE_PIN;
        pinDcBrake <= 1'b1;
        repeat (6) @(posedge ref_clk);
        // relay1 own/on, setupOwn, reverse, dcBrake, relay2On, stops
        check("own", {8'h0, driveCmd[6:5], driveCmd[2], driveCmd[0],
              driveCmd[14], driveCmd[3], driveCmd[12], driveCmd[10]},
              16'h000c);
        end_sim();
    end
    // hang guard, well past the run
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        end_sim();
    end
endmodule
